// *** common/hss_defines.svh ***
// Constants for the home search and scan sequencer
`ifndef HSS_DEFINES_SVH
`define HSS_DEFINES_SVH
`define HSS_POS_MAX 32'sh7fffffff
`define HSS_POS_MIN (-32'sh7fffffff)
`define HSS_NEAR_DIST 32'sh00000064
`define HSS_ST_HOME 2
`define HSS_ST_CCW 1
`define HSS_ST_CW 0
`define HSS_SPD_FULL 2'h2
`define HSS_SPD_SLOW 2'h1
`define HSS_SPD_NONE 2'h0
`endif

// *** common/hss_pkg.sv ***
// Types of the home search and scan sequencer
package hss_pkg;
  typedef enum logic [3:0] {
    HSS_IDLE = 4'h0,
    HSS_SCAN = 4'h1,
    HSS_SEEK = 4'h2,
    HSS_OVER = 4'h3,
    HSS_PASS1 = 4'h4,
    HSS_PASS2 = 4'h5,
    HSS_FINAL = 4'h6,
    HSS_NEAR = 4'h7,
    HSS_HSCAN = 4'h8,
    HSS_DECEL = 4'h9
  } hss_state_e;
  // Motion drive request to the pulse generator
  typedef struct packed {
    logic step;
    logic dir_ccw;
    logic [1:0] speed;
  } hss_drive_s;
  // Saved home data
  typedef struct packed {
    logic found;
    logic dir_ccw;
    logic signed [31:0] pos;
  } hss_home_s;
endpackage

// *** hdl/hss_sequencer.sv ***
// Home search and scan sequencer for one motor channel
`timescale 1ns/10ps
`include "hss_defines.svh"
module hss_sequencer #(
  parameter logic [1:0] CHANNEL = 2'h0
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic REMOTE_MODE,
  input wire logic [1:0] CMD_CHANNEL,
  input wire logic CONST_SCAN_CW_CMD,
  input wire logic CONST_SCAN_CCW_CMD,
  input wire logic AUTO_HOME_SEARCH_CMD,
  input wire logic REPEAT_HOME_SEARCH_CMD,
  input wire logic HOME_SCAN_CW_CMD,
  input wire logic HOME_SCAN_CCW_CMD,
  input wire logic SLOW_STOP_CMD,
  input wire logic FAST_STOP_CMD,
  input wire logic SEARCH_DIR_CCW,
  input wire logic DECEL_DONE,
  input wire logic STEP_DONE,
  input wire logic HOME_SENSOR,
  input wire logic CW_LIMIT,
  input wire logic CCW_LIMIT,
  input wire logic DIG_LIMIT_EN,
  input wire logic signed [31:0] DIG_LIMIT_CW,
  input wire logic signed [31:0] DIG_LIMIT_CCW,
  output hss_pkg::hss_drive_s DRIVE,
  output logic DECEL_REQ,
  output logic BUSY,
  output logic signed [31:0] POSITION,
  output hss_pkg::hss_home_s HOME_DATA,
  output logic SAVED_SEARCH_DIR_CCW,
  output logic [2:0] SENSOR_STATUS
);
  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  hss_pkg::hss_state_e state;
  hss_pkg::hss_state_e next_state;
  logic dir_ccw;
  logic next_dir_ccw;
  logic [1:0] speed;
  logic [1:0] next_speed;
  logic reversed;
  logic next_reversed;
  logic signed [31:0] home_pos;
  logic home_found;
  logic home_dir;
  logic save_home;
  // Start commands reach this channel only in remote mode
  wire sel = REMOTE_MODE && (CMD_CHANNEL == CHANNEL);
  wire go_cscan_cw = sel && CONST_SCAN_CW_CMD;
  wire go_cscan_ccw = sel && CONST_SCAN_CCW_CMD;
  wire go_auto = sel && AUTO_HOME_SEARCH_CMD;
  wire go_rep = sel && REPEAT_HOME_SEARCH_CMD && home_found;
  wire go_hs_cw = sel && HOME_SCAN_CW_CMD;
  wire go_hs_ccw = sel && HOME_SCAN_CCW_CMD;
  // Stops are accepted in either mode
  wire my_ch = (CMD_CHANNEL == CHANNEL);
  wire stop_slow = my_ch && SLOW_STOP_CMD;
  wire stop_fast = my_ch && FAST_STOP_CMD;
  wire idle = (state == hss_pkg::HSS_IDLE);
  // Limit in the direction of travel, switch or digital
  wire dig_cw = DIG_LIMIT_EN && (POSITION >= DIG_LIMIT_CW);
  wire dig_ccw = DIG_LIMIT_EN && (POSITION <= DIG_LIMIT_CCW);
  wire lim_hit = dir_ccw ? (CCW_LIMIT || dig_ccw) : (CW_LIMIT || dig_cw);
  wire signed [31:0] near_pt = home_dir ? (home_pos + `HSS_NEAR_DIST)
                                        : (home_pos - `HSS_NEAR_DIST);
  // Repeat search first heads for the near point, whichever side it is on
  wire at_near = (POSITION == near_pt);
  wire near_is_ccw = (POSITION > near_pt);
  wire stepping = DRIVE.step;
  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  // Chooses motion phase, direction and speed
  always_comb begin
    next_state = state;
    next_dir_ccw = dir_ccw;
    next_speed = speed;
    next_reversed = reversed;
    save_home = 1'b0;
    if (stop_fast && !idle) begin
      next_state = hss_pkg::HSS_IDLE;
      next_speed = `HSS_SPD_NONE;
    end else if (stop_slow && !idle) begin
      next_state = hss_pkg::HSS_DECEL;
    end else begin
      case (state)
        hss_pkg::HSS_IDLE: begin
          next_reversed = 1'b0;
          if (go_cscan_cw || go_cscan_ccw) begin
            next_state = hss_pkg::HSS_SCAN;
            next_dir_ccw = go_cscan_ccw;
            next_speed = `HSS_SPD_FULL;
          end else if (go_auto) begin
            next_state = hss_pkg::HSS_SEEK;
            next_dir_ccw = SEARCH_DIR_CCW;
            next_speed = `HSS_SPD_FULL;
          end else if (go_rep) begin
            next_state = hss_pkg::HSS_NEAR;
            next_dir_ccw = near_is_ccw;
            next_speed = `HSS_SPD_FULL;
          end else if (go_hs_cw || go_hs_ccw) begin
            next_state = hss_pkg::HSS_HSCAN;
            next_dir_ccw = go_hs_ccw;
            next_speed = `HSS_SPD_FULL;
          end
        end
        hss_pkg::HSS_SCAN: begin
          if (lim_hit) begin
            next_state = hss_pkg::HSS_IDLE;
            next_speed = `HSS_SPD_NONE;
          end
        end
        hss_pkg::HSS_SEEK: begin
          if (HOME_SENSOR) begin
            next_state = hss_pkg::HSS_OVER;
          end else if (lim_hit) begin
            next_dir_ccw = !dir_ccw;
            next_reversed = 1'b1;
          end
        end
        hss_pkg::HSS_OVER: begin
          if (DECEL_DONE) begin
            next_speed = `HSS_SPD_SLOW;
            if (reversed) begin
              next_state = hss_pkg::HSS_PASS1;
            end else begin
              next_state = hss_pkg::HSS_FINAL;
              next_dir_ccw = !dir_ccw;
            end
          end
        end
        hss_pkg::HSS_PASS1: begin
          // Keep moving slowly until clear of the sensor, then turn
          if (!HOME_SENSOR) begin
            next_state = hss_pkg::HSS_PASS2;
            next_dir_ccw = !dir_ccw;
          end
        end
        hss_pkg::HSS_PASS2: begin
          if (HOME_SENSOR) begin
            next_reversed = 1'b0;
          end else if (!reversed) begin
            next_state = hss_pkg::HSS_FINAL;
            next_dir_ccw = !dir_ccw;
          end
        end
        hss_pkg::HSS_FINAL: begin
          if (HOME_SENSOR) begin
            next_state = hss_pkg::HSS_IDLE;
            next_speed = `HSS_SPD_NONE;
            save_home = 1'b1;
          end
        end
        hss_pkg::HSS_NEAR: begin
          // Fast leg to the near point, then slow leg in stored direction
          if (speed == `HSS_SPD_SLOW) begin
            if (HOME_SENSOR) begin
              next_state = hss_pkg::HSS_IDLE;
              next_speed = `HSS_SPD_NONE;
            end
          end else if (at_near) begin
            next_speed = `HSS_SPD_SLOW;
            next_dir_ccw = home_dir;
          end
        end
        hss_pkg::HSS_HSCAN: begin
          if (HOME_SENSOR || lim_hit) begin
            next_state = hss_pkg::HSS_IDLE;
            next_speed = `HSS_SPD_NONE;
          end
        end
        hss_pkg::HSS_DECEL: begin
          if (DECEL_DONE) begin
            next_state = hss_pkg::HSS_IDLE;
            next_speed = `HSS_SPD_NONE;
          end
        end
        default: begin
          next_state = hss_pkg::HSS_IDLE;
          next_speed = `HSS_SPD_NONE;
        end
      endcase
    end
  end
  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  // Phase, direction, speed and reversal memory
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state <= hss_pkg::HSS_IDLE;
      dir_ccw <= 1'b0;
      speed <= `HSS_SPD_NONE;
      reversed <= 1'b0;
    end else begin
      state <= next_state;
      dir_ccw <= next_dir_ccw;
      speed <= next_speed;
      reversed <= next_reversed;
    end
  end
  // Home memory written when the final approach ends
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      home_pos <= 32'sh00000000;
      home_found <= 1'b0;
      home_dir <= 1'b0;
      SAVED_SEARCH_DIR_CCW <= 1'b0;
    end else if (save_home) begin
      home_pos <= POSITION;
      home_found <= 1'b1;
      home_dir <= dir_ccw;
      SAVED_SEARCH_DIR_CCW <= SEARCH_DIR_CCW;
    end
  end
  // Position counter follows each step and saturates
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      POSITION <= 32'sh00000000;
    end else if (STEP_DONE && stepping) begin
      if (dir_ccw && POSITION != `HSS_POS_MIN) begin
        POSITION <= POSITION - 32'sh00000001;
      end else if (!dir_ccw && POSITION != `HSS_POS_MAX) begin
        POSITION <= POSITION + 32'sh00000001;
      end
    end
  end
  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Drive request and busy registered from next state, sensor status from the inputs
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      DRIVE <= '0;
      DECEL_REQ <= 1'b0;
      BUSY <= 1'b0;
      SENSOR_STATUS <= 3'h0;
    end else begin
      DRIVE.step <= (next_state != hss_pkg::HSS_IDLE);
      // Direction shows zero while stopped so an idle drive reads all zero
      DRIVE.dir_ccw <= next_dir_ccw && (next_state != hss_pkg::HSS_IDLE);
      DRIVE.speed <= next_speed;
      DECEL_REQ <= (next_state == hss_pkg::HSS_DECEL)
                   || (next_state == hss_pkg::HSS_OVER);
      BUSY <= (next_state != hss_pkg::HSS_IDLE);
      SENSOR_STATUS[`HSS_ST_HOME] <= HOME_SENSOR;
      SENSOR_STATUS[`HSS_ST_CCW] <= CCW_LIMIT;
      SENSOR_STATUS[`HSS_ST_CW] <= CW_LIMIT;
    end
  end
  assign HOME_DATA = '{found: home_found, dir_ccw: home_dir,
                       pos: home_pos};
endmodule // hss_sequencer

// *** test/hss_motor_model.sv ***
// Motor driver, shaft and sensor model facing the sequencer
`timescale 1ns/10ps
module hss_motor_model #(
  parameter int HOME_LO = 50,
  parameter int HOME_HI = 52,
  parameter int LIM = 300
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire hss_pkg::hss_drive_s DRIVE,
  input wire logic DECEL_REQ,
  output logic STEP_DONE,
  output logic DECEL_DONE,
  output logic HOME_SENSOR,
  output logic CW_LIMIT,
  output logic CCW_LIMIT
);
  int mpos = 0;
  logic [2:0] dc = 3'h0;
  // Sensors follow the shaft; switches stay made beyond their point
  assign HOME_SENSOR = mpos >= HOME_LO && mpos <= HOME_HI;
  assign CW_LIMIT = mpos >= LIM;
  assign CCW_LIMIT = mpos <= -LIM;
  // One step every two cycles while driven; a ramp takes a few cycles
  always_ff @(posedge CLK) begin
    STEP_DONE <= !SYS_RST && DRIVE.step && !STEP_DONE;
    DECEL_DONE <= DECEL_REQ && dc == 3'h4;
    dc <= DECEL_REQ ? dc + 3'h1 : 3'h0;
    if (STEP_DONE && DRIVE.step) mpos <= DRIVE.dir_ccw ? mpos - 1 : mpos + 1;
  end
endmodule // hss_motor_model

// *** test/hss_sequencer_sva.sv ***
// Assertion checker for the home search and scan sequencer
`timescale 1ns/10ps
module hss_sequencer_sva (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic REMOTE_MODE,
  input wire logic [1:0] CMD_CHANNEL,
  input wire logic CONST_SCAN_CW_CMD,
  input wire logic AUTO_HOME_SEARCH_CMD,
  input wire logic REPEAT_HOME_SEARCH_CMD,
  input wire logic HOME_SCAN_CW_CMD,
  input wire logic HOME_SCAN_CCW_CMD,
  input wire logic SLOW_STOP_CMD,
  input wire logic FAST_STOP_CMD,
  input wire logic SEARCH_DIR_CCW,
  input wire logic HOME_SENSOR,
  input wire logic CW_LIMIT,
  input wire logic CCW_LIMIT,
  input wire hss_pkg::hss_drive_s DRIVE,
  input wire logic DECEL_REQ,
  input wire logic BUSY,
  input wire logic signed [31:0] POSITION,
  input wire hss_pkg::hss_home_s HOME_DATA,
  input wire logic [2:0] SENSOR_STATUS
);
  logic hs_on;
  wire go = !BUSY && REMOTE_MODE && CMD_CHANNEL == 2'h0 && !SLOW_STOP_CMD
    && !FAST_STOP_CMD;
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // Marks a running directional home scan
  always_ff @(posedge CLK) begin
    hs_on <= !SYS_RST && ((go && (HOME_SCAN_CW_CMD || HOME_SCAN_CCW_CMD))
      || (hs_on && BUSY));
  end
  sequence s_scan_cw;
    go && CONST_SCAN_CW_CMD && !AUTO_HOME_SEARCH_CMD && !CW_LIMIT;
  endsequence
  a_idle_no_drive: assert property (!BUSY |-> DRIVE == '0)
    else $error("drive active while idle");
  a_local_refused: assert property (!BUSY && !REMOTE_MODE |=> !BUSY)
    else $error("start taken in local mode");
  a_scan_cw_start: assert property (s_scan_cw |=>
    BUSY && DRIVE == 4'ha) else $error("constant scan start wrong");
  a_auto_dir: assert property (go && AUTO_HOME_SEARCH_CMD |=>
    BUSY && DRIVE.dir_ccw == $past(SEARCH_DIR_CCW))
    else $error("auto search direction wrong");
  a_repeat_refused: assert property (go && REPEAT_HOME_SEARCH_CMD
    && !HOME_DATA.found |=> !BUSY) else $error("repeat without home ran");
  a_fast_stop: assert property (BUSY && FAST_STOP_CMD
    && CMD_CHANNEL == 2'h0 |=> !BUSY && !DECEL_REQ)
    else $error("fast stop not immediate");
  a_status_lag: assert property (!$past(SYS_RST) |-> SENSOR_STATUS
    == $past({HOME_SENSOR, CCW_LIMIT, CW_LIMIT})) else $error("status bits");
  a_hscan_abrupt: assert property (hs_on && BUSY && HOME_SENSOR
    && !DECEL_REQ |=> !BUSY) else $error("home scan not stopped");
  a_home_flag: assert property ($rose(HOME_DATA.found) |->
    $past(BUSY) && !BUSY) else $error("home flag set while moving");
  a_pos_bound: assert property (POSITION != 32'sh80000000)
    else $error("position beyond bound");
endmodule // hss_sequencer_sva
bind hss_sequencer hss_sequencer_sva i_hss_sequencer_sva(.CLK, .SYS_RST,
  .REMOTE_MODE, .CMD_CHANNEL, .CONST_SCAN_CW_CMD, .AUTO_HOME_SEARCH_CMD,
  .REPEAT_HOME_SEARCH_CMD, .HOME_SCAN_CW_CMD, .HOME_SCAN_CCW_CMD,
  .SLOW_STOP_CMD, .FAST_STOP_CMD, .SEARCH_DIR_CCW, .HOME_SENSOR, .CW_LIMIT,
  .CCW_LIMIT, .DRIVE, .DECEL_REQ, .BUSY, .POSITION, .HOME_DATA,
  .SENSOR_STATUS);

// *** test/testbench.sv ***
// Self-checking bench for the home search and scan sequencer
`timescale 1ns/10ps
module testbench;
  logic CLK = 0, SYS_RST = 1, REMOTE_MODE = 1, SEARCH_DIR_CCW = 1;
  logic [1:0] CMD_CHANNEL = 2'h0;
  logic [7:0] cmdv = 8'h00;
  logic STEP_DONE, DECEL_DONE, HOME_SENSOR, CW_LIMIT, CCW_LIMIT;
  logic DECEL_REQ, BUSY, SAVED_SEARCH_DIR_CCW;
  logic [2:0] SENSOR_STATUS;
  logic signed [31:0] POSITION;
  hss_pkg::hss_drive_s DRIVE;
  hss_pkg::hss_home_s HOME_DATA;
  int fail_count = 0, tests_run = 0;
  initial forever #50 CLK = ~CLK;
  // Digital limits off; the limit switches at LIM keep the counter far from its bounds
  hss_sequencer i_hss_sequencer(.CLK, .SYS_RST, .REMOTE_MODE, .CMD_CHANNEL,
    .CONST_SCAN_CW_CMD(cmdv[0]), .CONST_SCAN_CCW_CMD(cmdv[1]),
    .AUTO_HOME_SEARCH_CMD(cmdv[2]), .REPEAT_HOME_SEARCH_CMD(cmdv[3]),
    .HOME_SCAN_CW_CMD(cmdv[4]), .HOME_SCAN_CCW_CMD(cmdv[5]),
    .SLOW_STOP_CMD(cmdv[6]), .FAST_STOP_CMD(cmdv[7]), .SEARCH_DIR_CCW,
    .DECEL_DONE, .STEP_DONE, .HOME_SENSOR, .CW_LIMIT, .CCW_LIMIT,
    .DIG_LIMIT_EN(1'b0), .DIG_LIMIT_CW(32'sh0), .DIG_LIMIT_CCW(32'sh0),
    .DRIVE, .DECEL_REQ, .BUSY, .POSITION, .HOME_DATA, .SAVED_SEARCH_DIR_CCW,
    .SENSOR_STATUS);
  hss_motor_model i_hss_motor_model(.CLK, .SYS_RST, .DRIVE, .DECEL_REQ,
    .STEP_DONE, .DECEL_DONE, .HOME_SENSOR, .CW_LIMIT, .CCW_LIMIT);
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task finish_test;
    if (fail_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task pulse(input int b);
    @(negedge CLK) cmdv[b] = 1'b1;
    @(negedge CLK) cmdv = 8'h00;
  endtask
  task run(input int b, input int n);
    pulse(b);
    repeat (n) @(negedge CLK);
  endtask
  task idle;
    int i;
    for (i = 0; i < 8000 && BUSY !== 1'b0; i++) @(negedge CLK);
    if (BUSY !== 1'b0) begin
      chk("timeout", 32'h0, 32'h1);
      finish_test;
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_refuse;
    REMOTE_MODE = 1'b0;
    pulse(0);
    chk("busy_local", 32'h0, {31'h0, BUSY});
    REMOTE_MODE = 1'b1;
    CMD_CHANNEL = 2'h1;
    pulse(0);
    chk("busy_chan", 32'h0, {31'h0, BUSY});
    CMD_CHANNEL = 2'h0;
    pulse(3);
    chk("busy_repeat", 32'h0, {31'h0, BUSY});
  endtask
  task t_scans;
    run(0, 20);
    chk("drive_cw", 32'ha, {28'h0, DRIVE});
    pulse(7);
    chk("fast_stop", 32'h0, {30'h0, DECEL_REQ, BUSY});
    run(1, 20);
    chk("drive_ccw", 32'he, {28'h0, DRIVE});
    pulse(6);
    chk("slow_stop", 32'h3, {30'h0, DECEL_REQ, BUSY});
    idle;
  endtask
  task t_auto;
    pulse(2);
    idle;
    chk("found", 32'h1, {31'h0, HOME_DATA.found});
    chk("at_home_rev", 32'h1, {31'h0, HOME_SENSOR});
    chk("saved_dir", 32'h1, {31'h0, SAVED_SEARCH_DIR_CCW});
    chk("home_pos", 32'd50, HOME_DATA.pos);
    chk("home_dir", 32'h0, {31'h0, HOME_DATA.dir_ccw});
    run(0, 20);
    pulse(7);
    pulse(2);
    idle;
    chk("at_home_fwd", 32'h1, {31'h0, HOME_SENSOR});
  endtask
  task t_repeat;
    run(0, 60);
    pulse(7);
    pulse(3);
    idle;
    chk("repeat_home", 32'h1, {31'h0, HOME_SENSOR});
    chk("repeat_pos", 32'd50, POSITION);
  endtask
  task t_hscan;
    // Each home scan starts from rest after a stop, never mid-run
    run(0, 20);
    pulse(7);
    pulse(5);
    idle;
    chk("hscan_ccw", 32'h1, {31'h0, HOME_SENSOR});
    chk("hscan_pos", 32'd52, POSITION);
    chk("idle_drive", 32'h0, {28'h0, DRIVE});
    run(0, 20);
    pulse(7);
    pulse(4);
    idle;
    chk("hscan_limit", 32'h1, {31'h0, CW_LIMIT});
  endtask
  initial begin
    repeat (2) @(negedge CLK);
    SYS_RST = 1'b0;
    t_refuse;
    t_scans;
    t_auto;
    t_repeat;
    t_hscan;
    finish_test;
  end
endmodule // testbench
